// >>> hw/p0gm_port.sv
// What this block does
// - alternate select outranks direction bit
// - alternate function sets pin direction itself
// - serial receive pin still follows direction
// - fixed per-bit alternate function map
// - external irqs pass only when selected
// - timer count pins sampled every 4 clocks
// - plain gpio: direction 0 out, 1 in
// - all port zero pins inputs during reset
// - reset setup kept until software writes
// - second port spi master during reset
// - reset values ff, 00, ff, 00 (data, high drive, direction, alt select)
// - high drive: odd source, even sink
// - after reset, spi master only when routing equals 01
`timescale 1ns/100ps
module p0gm_port #(
  parameter int SAMPLE_CYCLES = p0gm_pkg::SAMPLE_PERIOD_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic                  sfr_rd,
  input  wire logic [7:0]            sfr_wdata,
  output logic      [7:0]            sfr_rdata,
  input  wire logic [7:0]            pin_in,
  output logic      [7:0]            pin_out,
  output logic      [7:0]            pin_oe,
  output logic      [7:0]            pin_strong_source,
  output logic      [7:0]            pin_strong_sink,
  input  wire logic                  general_timer_output,
  input  wire logic                  serial_rx_drive,
  input  wire logic                  serial_tx,
  input  wire logic                  pwm_out,
  output logic                       serial_rx_in,
  output logic                       ext_irq_a_n,
  output logic                       ext_irq_b_n,
  output logic                       timer_a_count_in,
  output logic                       timer_b_count_in,
  input  wire logic [1:0]            spi_route,
  input  wire logic [3:0]            port_one_gpio_oe,
  output logic      [3:0]            port_one_oe
);
  import p0gm_pkg::*;

  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SAMPLE_CYCLES - 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > (1 << PHASE_W)) begin : g_bad_sample
    $error("sample period does not fit the phase counter");
  end

  p0gm_state_t st;
  p0gm_state_t next_st;
  logic [7:0]  pin_sync;
  logic [7:0]  alt_drive;
  logic [7:0]  alt_oe;
  logic [7:0]  gpio_oe;
  logic        sample_tick;

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  p0gm_sync #(
    .WIDTH    (8)
  ) u_pin_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ---------------------------------------------------------------
  // pin direction and drive
  // ---------------------------------------------------------------
  // alternate pins: fixed outputs, rx follows its direction bit
  assign alt_oe = st.alt_select & (ALT_OUT_MASK | (ALT_DIR_MASK & ~st.direction));
  // plain gpio: direction 0 drives the pin
  assign gpio_oe = ~st.alt_select & ~st.direction;
  // reset state has every oe low since alt 00 and direction ff
  assign pin_oe = alt_oe | gpio_oe;

  // peripheral sources per bit
  always_comb begin
    alt_drive                    = st.data;
    alt_drive[BIT_GENERAL_TIMER] = general_timer_output;
    alt_drive[BIT_SERIAL_RX]     = serial_rx_drive;
    alt_drive[BIT_SERIAL_TX]     = serial_tx;
    alt_drive[BIT_PWM]           = pwm_out;
  end

  // data register drives gpio outputs
  assign pin_out = (st.alt_select & alt_drive) | (~st.alt_select & st.data);

  // strength is a pad setting, harmless on inputs
  assign pin_strong_source = st.high_drive & ODD_PIN_MASK;
  assign pin_strong_sink   = st.high_drive & EVEN_PIN_MASK;

  // ---------------------------------------------------------------
  // inputs towards the peripherals
  // ---------------------------------------------------------------
  assign serial_rx_in = st.alt_select[BIT_SERIAL_RX] ? pin_sync[BIT_SERIAL_RX] : 1'b1;
  // idle high keeps a deselected irq line quiet
  assign ext_irq_a_n  = st.alt_select[BIT_IRQ_A] ? pin_sync[BIT_IRQ_A] : 1'b1;
  assign ext_irq_b_n  = st.alt_select[BIT_IRQ_B] ? pin_sync[BIT_IRQ_B] : 1'b1;
  // sampled values reach the timers only when selected
  assign timer_a_count_in = st.alt_select[BIT_TIMER_A] & st.count_in[0];
  assign timer_b_count_in = st.alt_select[BIT_TIMER_B] & st.count_in[1];
  assign sample_tick      = (st.phase == PHASE_LAST);

  // ---------------------------------------------------------------
  // second port pin directions
  // ---------------------------------------------------------------
  // data in is never driven, whatever the gpio logic asks
  always_comb begin
    if (!st.boot_done || spi_route == SPI_ROUTE_PORT_ONE) begin
      port_one_oe = SPI_MASTER_OE;
    end else begin
      port_one_oe = port_one_gpio_oe & ~SPI_DATA_IN_MASK;
    end
  end

  assign sfr_rdata = st.rdata;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.boot_done = 1'b1;
    // fixed-rate sampling; slow count edges are the price
    if (sample_tick) begin
      next_st.phase    = '0;
      next_st.count_in = {pin_sync[BIT_TIMER_B], pin_sync[BIT_TIMER_A]};
    end else begin
      next_st.phase = PHASE_W'(st.phase + 1'b1);
    end
    // writes are the only way off the reset setup
    if (sfr_wr) begin
      if (sfr_addr == ADDR_PORT_ZERO_DATA) begin
        next_st.data = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT_ZERO_HIGH_DRIVE) begin
        next_st.high_drive = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT_ZERO_DIRECTION) begin
        next_st.direction = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT_ZERO_ALT_SELECT) begin
        next_st.alt_select = sfr_wdata;
      end
    end
    // data address reads pin levels, not the latch
    if (sfr_rd) begin
      if (sfr_addr == ADDR_PORT_ZERO_DATA) begin
        next_st.rdata = pin_sync;
      end else if (sfr_addr == ADDR_PORT_ZERO_HIGH_DRIVE) begin
        next_st.rdata = st.high_drive;
      end else if (sfr_addr == ADDR_PORT_ZERO_DIRECTION) begin
        next_st.rdata = st.direction;
      end else if (sfr_addr == ADDR_PORT_ZERO_ALT_SELECT) begin
        next_st.rdata = st.alt_select;
      end else begin
        next_st.rdata = RST_READ_DATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st.data       <= RST_PORT_ZERO_DATA;
      st.high_drive <= RST_PORT_ZERO_HIGH_DRIVE;
      st.direction  <= RST_PORT_ZERO_DIRECTION;
      st.alt_select <= RST_PORT_ZERO_ALT_SELECT;
      st.rdata      <= RST_READ_DATA;
      st.phase      <= RST_PHASE;
      st.count_in   <= 2'h0;
      st.boot_done  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence tick_gap_s;
    !sample_tick [*3] ##1 sample_tick;
  endsequence

  // one software write to the alternate select register
  sequence alt_write_s;
    sfr_wr && sfr_addr == ADDR_PORT_ZERO_ALT_SELECT;
  endsequence

  alt_out_priority_a : assert property (
    (pin_oe & st.alt_select & ALT_OUT_MASK) == (st.alt_select & ALT_OUT_MASK))
    else $error("selected output function not driving");

  alt_in_forced_a : assert property (
    (pin_oe & st.alt_select & ~(ALT_OUT_MASK | ALT_DIR_MASK)) == 8'h00)
    else $error("selected input function is driving");

  rx_dir_kept_a : assert property (
    st.alt_select[BIT_SERIAL_RX] |-> pin_oe[BIT_SERIAL_RX] == !st.direction[BIT_SERIAL_RX])
    else $error("serial receive direction ignores its bit");

  tx_source_a : assert property (
    st.alt_select[BIT_SERIAL_TX] |-> pin_out[BIT_SERIAL_TX] == serial_tx)
    else $error("transmit pin not driven by serial output");

  irq_gate_a : assert property (
    !st.alt_select[BIT_IRQ_A] |-> ext_irq_a_n)
    else $error("irq a reaches logic while deselected");

  sample_rate_a : assert property (
    sample_tick |=> tick_gap_s)
    else $error("timer inputs not sampled every four clocks");

  count_hold_a : assert property (
    !$past(sample_tick) |-> $stable(st.count_in))
    else $error("timer input sampled off its slot");

  gpio_dir_a : assert property (
    !st.alt_select[BIT_PWM] |-> pin_oe[BIT_PWM] == !st.direction[BIT_PWM])
    else $error("gpio direction wrong");

  dir_write_a : assert property (
    sfr_wr && sfr_addr == ADDR_PORT_ZERO_DIRECTION |=> st.direction == $past(sfr_wdata))
    else $error("direction write lost");

  dir_hold_a : assert property (
    !(sfr_wr && sfr_addr == ADDR_PORT_ZERO_DIRECTION) |=> $stable(st.direction))
    else $error("direction changed without a write");

  spi_boot_a : assert property (
    !st.boot_done |-> port_one_oe == SPI_MASTER_OE)
    else $error("second port not spi master at reset");

  drive_split_a : assert property (
    pin_strong_source[1] == st.high_drive[1] && !pin_strong_sink[1]
    && pin_strong_sink[0] == st.high_drive[0] && !pin_strong_source[0])
    else $error("high drive polarity wrong");

  spi_route_a : assert property (
    st.boot_done && spi_route != SPI_ROUTE_PORT_ONE
    |-> port_one_oe == (port_one_gpio_oe & ~SPI_DATA_IN_MASK))
    else $error("second port not back to gpio");

  pin_read_a : assert property (
    sfr_rd && sfr_addr == ADDR_PORT_ZERO_DATA |=> sfr_rdata == $past(pin_sync))
    else $error("data read does not return pin levels");

  irq_b_gate_a : assert property (
    !st.alt_select[BIT_IRQ_B] |-> ext_irq_b_n)
    else $error("irq b reaches logic while deselected");

  irq_a_pass_a : assert property (
    st.alt_select[BIT_IRQ_A] |-> ext_irq_a_n == pin_sync[BIT_IRQ_A])
    else $error("selected irq a does not follow its pin");

  timer_a_gate_a : assert property (
    !st.alt_select[BIT_TIMER_A] |-> !timer_a_count_in)
    else $error("timer a input active while deselected");

  timer_b_gate_a : assert property (
    !st.alt_select[BIT_TIMER_B] |-> !timer_b_count_in)
    else $error("timer b input active while deselected");

  count_take_a : assert property (
    sample_tick |=> st.count_in[0] == $past(pin_sync[BIT_TIMER_A]))
    else $error("timer a pin not taken at its slot");

  general_timer_output_drive_a : assert property (
    st.alt_select[BIT_GENERAL_TIMER] |-> pin_oe[BIT_GENERAL_TIMER]
    && pin_out[BIT_GENERAL_TIMER] == general_timer_output)
    else $error("timer output pin not driven by timer");

  pwm_drive_a : assert property (
    st.alt_select[BIT_PWM] |-> pin_oe[BIT_PWM] && pin_out[BIT_PWM] == pwm_out)
    else $error("pwm pin not driven by pwm");

  gpio_out_a : assert property (
    (~st.alt_select & ~st.direction & (pin_out ^ st.data)) == 8'h00)
    else $error("gpio output does not show the data register");

  gpio_in_a : assert property (
    (~st.alt_select & st.direction & pin_oe) == 8'h00)
    else $error("gpio input pin is driving");

  alt_write_a : assert property (
    alt_write_s |=> st.alt_select == $past(sfr_wdata))
    else $error("alternate select write lost");

  alt_hold_a : assert property (
    !(sfr_wr && sfr_addr == ADDR_PORT_ZERO_ALT_SELECT) |=> $stable(st.alt_select))
    else $error("alternate select changed without a write");

  data_write_a : assert property (
    sfr_wr && sfr_addr == ADDR_PORT_ZERO_DATA |=> st.data == $past(sfr_wdata))
    else $error("data register write lost");

  drive_write_a : assert property (
    sfr_wr && sfr_addr == ADDR_PORT_ZERO_HIGH_DRIVE |=> st.high_drive == $past(sfr_wdata))
    else $error("high drive write lost");

  rdata_hold_a : assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");

endmodule : p0gm_port

// >>> hw/p0gm_pkg.sv
package p0gm_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_ZERO_DATA       = 8'h80;
  localparam logic [7:0] ADDR_PORT_ZERO_HIGH_DRIVE = 8'h93;
  localparam logic [7:0] ADDR_PORT_ZERO_DIRECTION  = 8'h94;
  localparam logic [7:0] ADDR_PORT_ZERO_ALT_SELECT = 8'h95;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_ZERO_DATA       = 8'hff;
  localparam logic [7:0] RST_PORT_ZERO_HIGH_DRIVE = 8'h00;
  localparam logic [7:0] RST_PORT_ZERO_DIRECTION  = 8'hff;
  localparam logic [7:0] RST_PORT_ZERO_ALT_SELECT = 8'h00;
  localparam logic [7:0] RST_READ_DATA            = 8'h00;

  // ---------------------------------------------------------------
  // pin positions of the alternate functions
  // ---------------------------------------------------------------
  localparam int BIT_GENERAL_TIMER = 0;
  localparam int BIT_SERIAL_RX     = 1;
  localparam int BIT_SERIAL_TX     = 2;
  localparam int BIT_IRQ_A         = 3;
  localparam int BIT_IRQ_B         = 4;
  localparam int BIT_TIMER_A       = 5;
  localparam int BIT_TIMER_B       = 6;
  localparam int BIT_PWM           = 7;

  // pins whose alternate function always drives
  localparam logic [7:0] ALT_OUT_MASK = 8'h85;
  // serial receive pin keeps its direction bit
  localparam logic [7:0] ALT_DIR_MASK = 8'h02;
  // odd pins source strongly, even pins sink strongly
  localparam logic [7:0] ODD_PIN_MASK  = 8'haa;
  localparam logic [7:0] EVEN_PIN_MASK = 8'h55;

  // ---------------------------------------------------------------
  // second port routing and its spi master pin directions
  // ---------------------------------------------------------------
  localparam logic [1:0] SPI_ROUTE_PORT_ONE = 2'h1;
  // bit 0 clock, 1 data out, 2 data in, 3 select
  localparam logic [3:0] SPI_MASTER_OE      = 4'hb;
  localparam logic [3:0] SPI_DATA_IN_MASK   = 4'h4;

  // ---------------------------------------------------------------
  // timer count input sampling
  // ---------------------------------------------------------------
  localparam int         SAMPLE_PERIOD_CYCLES = 4;
  localparam int         PHASE_W              = 2;
  localparam logic [1:0] RST_PHASE            = 2'h0;

  typedef struct packed {
    logic [7:0]         data;
    logic [7:0]         high_drive;
    logic [7:0]         direction;
    logic [7:0]         alt_select;
    logic [7:0]         rdata;
    logic [PHASE_W-1:0] phase;
    logic [1:0]         count_in;
    logic               boot_done;
  } p0gm_state_t;

endpackage : p0gm_pkg

// >>> hw/p0gm_sync.sv
`timescale 1ns/100ps
module p0gm_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
  } p0gm_sync_t;

  p0gm_sync_t st;
  p0gm_sync_t next_st;

  // ---------------------------------------------------------------
  // two flops; the first one feeds only the second
  // ---------------------------------------------------------------
  always_comb begin
    next_st.stage_one = async_in;
    next_st.stage_two = st.stage_one;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage_two;

endmodule : p0gm_sync

// >>> bench/p0gm_board.sv
`timescale 1ns/100ps
module p0gm_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  // ---------------------------------------------------------------
  // pad resolution
  // ---------------------------------------------------------------
  // board devices always drive; the port wins where it drives, so no contention model
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : p0gm_board

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import p0gm_pkg::*;
  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  sfr_addr  = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  ext_level = 8'hff;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic        gto       = 1'b0;
  logic        rxd       = 1'b0;
  logic        txd       = 1'b0;
  logic        pwm       = 1'b0;
  logic [1:0]  spi_route = 2'h0;
  logic [3:0]  p1_oe_in  = 4'h0;
  logic [7:0]  sfr_rdata, pin_in, pin_out, pin_oe, src, snk;
  logic        rx_in, irq_a_n, irq_b_n, tmr_a, tmr_b;
  logic [3:0]  port_one_oe;
  logic [7:0]  r, dat, drv, dir, alt, oe, pad;
  integer      seed         = 32'hf6c31a92;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cyc          = 0;

  p0gm_port #(.SAMPLE_CYCLES(4)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_strong_source(src), .pin_strong_sink(snk),
    .general_timer_output(gto), .serial_rx_drive(rxd), .serial_tx(txd), .pwm_out(pwm),
    .serial_rx_in(rx_in), .ext_irq_a_n(irq_a_n), .ext_irq_b_n(irq_b_n),
    .timer_a_count_in(tmr_a), .timer_b_count_in(tmr_b), .spi_route(spi_route),
    .port_one_gpio_oe(p1_oe_in), .port_one_oe(port_one_oe));

  p0gm_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  // ---------------------------------------------------------------
  // clock, watchdog and helpers
  // ---------------------------------------------------------------
  always #2 core_clk = ~core_clk;

  // the whole run needs about 1070 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe dropped with an idle cycle so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk); #1;
    sfr_wr = 1'b0;
    @(posedge core_clk); #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk); #1;
    d = sfr_rdata;
    sfr_rd = 1'b0;
    @(posedge core_clk); #1;
  endtask : rd

  // alt outputs on 0,2,7, alt inputs on 3..6, rx pin keeps its direction bit
  function automatic logic [7:0] exp_oe(input logic [7:0] a, input logic [7:0] d);
    return (a & 8'h85) | (~a & ~d) | (a & 8'h02 & ~d);
  endfunction : exp_oe

  function automatic logic [7:0] exp_out(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a[0]) v[0] = gto;
    if (a[1]) v[1] = rxd;
    if (a[2]) v[2] = txd;
    if (a[7]) v[7] = pwm;
    return v;
  endfunction : exp_out

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    chk(pin_oe, 8'h00);
    chk({4'h0, port_one_oe}, 8'h0b);
    reset_n = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk(pin_oe, 8'h00);
    rd(8'h80, r);
    chk(r, 8'hff);
    rd(8'h93, r);
    chk(r, 8'h00);
    rd(8'h94, r);
    chk(r, 8'hff);
    rd(8'h95, r);
    chk(r, 8'h00);
    rd(8'h81, r);
    chk(r, 8'h00);
    $display("test reset done");
    // random setups, first two are all-alt corners
    for (int k = 0; k < 40; k++) begin
      dat = 8'($random(seed));
      drv = 8'($random(seed));
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      alt = (k < 2) ? 8'hff : 8'($random(seed));
      {gto, rxd, txd, pwm} = 4'($random(seed));
      ext_level = 8'($random(seed));
      wr(8'h80, dat);
      wr(8'h93, drv);
      wr(8'h94, dir);
      wr(8'h95, alt);
      repeat (10) @(posedge core_clk);
      #1;
      oe = exp_oe(alt, dir);
      pad = (exp_out(alt, dat) & oe) | (ext_level & ~oe);
      chk(pin_oe, oe);
      chk(pin_out & oe, pad & oe);
      chk(src, drv & 8'haa);
      chk(snk, drv & 8'h55);
      chk({5'h0, irq_b_n, irq_a_n, rx_in},
          {5'h0, ~alt[4] | pad[4], ~alt[3] | pad[3], ~alt[1] | pad[1]});
      chk({6'h0, tmr_b, tmr_a}, {6'h0, pad[6] & alt[6], pad[5] & alt[5]});
      rd(8'h80, r);
      chk(r, pad);
      rd(8'h94, r);
      chk(r, dir);
      rd(8'h95, r);
      chk(r, alt);
      rd(8'h93, r);
      chk(r, drv);
    end
    $display("test port mux done");
    for (int k = 0; k < 8; k++) begin
      spi_route = k[1:0];
      p1_oe_in = 4'($random(seed));
      @(posedge core_clk); #1;
      chk({4'h0, port_one_oe},
          {4'h0, (spi_route == 2'h1) ? 4'hb : (p1_oe_in & 4'hb)});
    end
    $display("test spi routing done");
    end_of_test();
  end
endmodule : testbench
